// ---- src/wsw_map.svh ----
// constants for the watchdog service window block
// assumes inclusion by wsw_top and wsw_monitor
`ifndef WSW_MAP_SVH
`define WSW_MAP_SVH
// service register field positions
`define WSW_WIN_HI       7
`define WSW_WIN_LO       6
`define WSW_KEY_HI       5
`define WSW_KEY_LO       1
`define WSW_CKM_BIT      0
// fixed key pattern
`define WSW_KEY_VAL      5'h0c
// service register value after reset: max window, monitor on, key hidden
`define WSW_SVC_RST      8'hc1
// limits in idle-timer clocks
`define WSW_LOWER_LIM    17'h00800
`define WSW_UPPER_8K     17'h02000
`define WSW_UPPER_16K    17'h04000
`define WSW_UPPER_32K    17'h08000
`define WSW_UPPER_64K    17'h10000
// fault pin hold after the pin reads low, in idle-timer clocks
`define WSW_HOLD_CNT     5'h18
// clock monitor: instruction clock edges absent for this many microseconds, scaled to ref cycles
`define WSW_CKM_TIMEOUT_US 100
`define WSW_CLK_MHZ        100
`define WSW_CKM_CYC        (`WSW_CKM_TIMEOUT_US * `WSW_CLK_MHZ)
`endif

// ---- src/wsw_pkg.sv ----
// types for the watchdog service window block
// assumes nothing outside itself
package wsw_pkg;
    typedef enum logic [1:0]
    {
        WSW_UNCONF = 2'b00,
        WSW_ARMED  = 2'b01,
        WSW_FAULT  = 2'b10,
        WSW_HOLD   = 2'b11
    } wsw_state_t;
endpackage : wsw_pkg

// ---- src/wsw_sync.sv ----
// two-flop synchroniser for one level
// assumes the input may come from any clock domain
`timescale 1ns/1ps
`default_nettype none
module wsw_sync
(
    input  wire logic i_ref_clk,
    input  wire logic i_rst,
    input  wire logic i_d,
    output var  logic o_q
);
    logic meta_r;
    // ========================================
    // two stages; first stage read only by second
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            meta_r <= 1'b0;
            o_q    <= 1'b0;
        end
        else
        begin
            meta_r <= i_d;
            o_q    <= meta_r;
        end
    end
endmodule : wsw_sync
`default_nettype wire

// ---- src/wsw_top.sv ----
// watchdog with service window and clock monitor
// assumes idle-timer and instruction clocks arrive as asynchronous levels
// and a write strobe with 8-bit data to the service register on the ref clock
`timescale 1ns/1ps
`default_nettype none
`include "wsw_map.svh"
module wsw_top
    import wsw_pkg::*;
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst,
    input  wire logic       i_wd_option,
    input  wire logic       i_idle_timer_clk,
    input  wire logic       i_instr_clk,
    input  wire logic       i_svc_wr,
    input  wire logic [7:0] i_svc_wdata,
    output logic      [7:0] o_svc_rdata,
    input  wire logic       i_fault_pin_in,
    output logic            o_fault_pin_out,
    output logic            o_fault_pin_oe_n,
    output logic            o_wd_error
);
    wsw_state_t  state_r;
    logic        tick_s;
    logic        tick_d_r;
    logic        icl_s;
    logic        icl_d_r;
    logic        pin_s;
    logic [1:0]  win_r;
    logic        ckm_en_r;
    logic [16:0] upper_cnt_r;
    logic [11:0] lower_cnt_r;
    logic        lower_ok_r;
    logic [4:0]  hold_cnt_r;
    logic [13:0] ckm_cnt_r;
    logic        ckm_err_r;
    logic [16:0] upper_lim;
    logic        tick;
    logic        key_ok;
    logic        fields_ok;
    logic        svc_ok;
    logic        svc_bad;
    logic        upper_exp;
    logic        pin_low;

    // ========================================
    // input synchronisers
    wsw_sync u_sync_tick
    (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_d       (i_idle_timer_clk),
        .o_q       (tick_s)
    );
    wsw_sync u_sync_icl
    (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_d       (i_instr_clk),
        .o_q       (icl_s)
    );
    wsw_sync u_sync_pin
    (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_d       (i_fault_pin_in),
        .o_q       (pin_s)
    );

    // ========================================
    // edge detect on synchronised clocks
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            tick_d_r <= 1'b0;
            icl_d_r  <= 1'b0;
        end
        else
        begin
            tick_d_r <= tick_s;
            icl_d_r  <= icl_s;
        end
    end
    assign tick    = tick_s & ~tick_d_r;
    assign pin_low = ~pin_s;

    // ========================================
    // service decode
    always_comb
    begin
        unique case (win_r)
            2'b00: upper_lim = `WSW_UPPER_8K;
            2'b01: upper_lim = `WSW_UPPER_16K;
            2'b10: upper_lim = `WSW_UPPER_32K;
            2'b11: upper_lim = `WSW_UPPER_64K;
        endcase
    end
    assign key_ok = (i_svc_wdata[`WSW_KEY_HI:`WSW_KEY_LO] == `WSW_KEY_VAL);
    assign fields_ok = key_ok
                     && (i_svc_wdata[`WSW_WIN_HI:`WSW_WIN_LO] == win_r)
                     && (i_svc_wdata[`WSW_CKM_BIT] == ckm_en_r);
    assign svc_ok  = i_svc_wr && (state_r == WSW_ARMED) && fields_ok
                   && lower_ok_r;
    assign svc_bad = i_svc_wr && (state_r == WSW_ARMED)
                   && (!fields_ok || !lower_ok_r);
    assign upper_exp = (upper_cnt_r >= upper_lim);

    // ========================================
    // main state: configure, watch, fault, hold
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_r  <= WSW_UNCONF;
            win_r    <= 2'b11;
            ckm_en_r <= 1'b1;
        end
        else if (!i_wd_option)
        begin
            state_r <= WSW_UNCONF;
        end
        else
        begin
            unique case (state_r)
                WSW_UNCONF:
                begin
                    if (i_svc_wr && key_ok)
                    begin
                        win_r    <= i_svc_wdata[`WSW_WIN_HI:`WSW_WIN_LO];
                        ckm_en_r <= i_svc_wdata[`WSW_CKM_BIT];
                        state_r  <= WSW_ARMED;
                    end
                    else if (i_svc_wr || upper_exp)
                        state_r <= WSW_FAULT;
                end
                WSW_ARMED:
                begin
                    if (svc_bad || upper_exp)
                        state_r <= WSW_FAULT;
                end
                WSW_FAULT:
                begin
                    if (pin_low)
                        state_r <= WSW_HOLD;
                end
                WSW_HOLD:
                begin
                    if (hold_cnt_r == `WSW_HOLD_CNT && !ckm_err_r)
                        state_r <= WSW_ARMED;
                end
            endcase
        end
    end

    // ========================================
    // upper and lower limit counters, independent
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            upper_cnt_r <= 17'h00000;
        end
        else if (svc_ok || state_r == WSW_FAULT || state_r == WSW_HOLD
                 || !i_wd_option || (state_r == WSW_UNCONF && i_svc_wr))
        begin
            upper_cnt_r <= 17'h00000;
        end
        else if (tick && !upper_exp)
        begin
            upper_cnt_r <= upper_cnt_r + 17'h00001;
        end
    end
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            lower_cnt_r <= 12'h000;
            lower_ok_r  <= 1'b0;
        end
        else if (svc_ok || state_r != WSW_ARMED)
        begin
            lower_cnt_r <= 12'h000;
            lower_ok_r  <= 1'b0;
        end
        else if (tick && !lower_ok_r)
        begin
            lower_cnt_r <= lower_cnt_r + 12'h001;
            if ({5'h00, lower_cnt_r} == `WSW_LOWER_LIM - 17'h00001)
                lower_ok_r <= 1'b1;
        end
    end

    // ========================================
    // fault pin hold counter
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            hold_cnt_r <= 5'h00;
        else if (state_r != WSW_HOLD)
            hold_cnt_r <= 5'h00;
        else if (tick && hold_cnt_r != `WSW_HOLD_CNT)
            hold_cnt_r <= hold_cnt_r + 5'h01;
    end

    // ========================================
    // clock monitor: ref cycles since last instruction clock edge
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ckm_cnt_r <= 14'h0000;
            ckm_err_r <= 1'b0;
        end
        else if (!ckm_en_r || !i_wd_option || (icl_s & ~icl_d_r))
        begin
            ckm_cnt_r <= 14'h0000;
            ckm_err_r <= 1'b0;
        end
        else if (ckm_cnt_r == 14'(`WSW_CKM_CYC - 1))
        begin
            ckm_err_r <= 1'b1;
        end
        else
        begin
            ckm_cnt_r <= ckm_cnt_r + 14'h0001;
        end
    end

    // ========================================
    // outputs, all registered
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_fault_pin_out  <= 1'b0;
            o_fault_pin_oe_n <= 1'b1;
            o_wd_error       <= 1'b0;
            o_svc_rdata      <= `WSW_SVC_RST;
        end
        else
        begin
            o_fault_pin_out  <= 1'b0;
            o_fault_pin_oe_n <= !(state_r == WSW_FAULT || state_r == WSW_HOLD
                                  || ckm_err_r);
            o_wd_error       <= (state_r == WSW_FAULT || state_r == WSW_HOLD);
            o_svc_rdata      <= {win_r, 5'h00, ckm_en_r};
        end
    end
endmodule : wsw_top
`default_nettype wire

// ---- tb/wsw_monitor.sv ----
// checker for the service window block ports
// assumes a bind onto wsw_top, one ref clock domain
`timescale 1ns/1ps
`default_nettype none
`include "wsw_map.svh"
module wsw_monitor
    import wsw_pkg::*;
(
    input wire logic       i_ref_clk,
    input wire logic       i_rst,
    input wire logic       i_wd_option,
    input wire logic       i_idle_timer_clk,
    input wire logic       i_svc_wr,
    input wire logic [7:0] i_svc_wdata,
    input wire logic [7:0] o_svc_rdata,
    input wire logic       i_fault_pin_in,
    input wire logic       o_fault_pin_out,
    input wire logic       o_fault_pin_oe_n,
    input wire logic       o_wd_error
);
    // ==========================================
    // helper state
    logic       seen_wr_r;
    logic       idle_d_r;
    logic [5:0] ticks_r;
    // marks the first write taken since reset
    always_ff @(posedge i_ref_clk or posedge i_rst)
        if (i_rst) seen_wr_r <= 1'b0;
        else if (i_svc_wr && i_wd_option) seen_wr_r <= 1'b1;
    // idle clock edge finder
    always_ff @(posedge i_ref_clk or posedge i_rst)
        if (i_rst) idle_d_r <= 1'b0;
        else idle_d_r <= i_idle_timer_clk;
    // idle ticks while the pin reads low, saturating
    always_ff @(posedge i_ref_clk or posedge i_rst)
        if (i_rst) ticks_r <= 6'h00;
        else if (o_fault_pin_oe_n) ticks_r <= 6'h00;
        else if (!i_fault_pin_in && i_idle_timer_clk && !idle_d_r
                 && ticks_r != 6'h3f) ticks_r <= ticks_r + 6'h01;
    // ==========================================
    // properties
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    sequence take_s; i_svc_wr && i_wd_option && !o_wd_error; endsequence
    sequence bad_key_s;
        take_s ##0 i_svc_wdata[5:1] != `WSW_KEY_VAL;
    endsequence
    sequence first_cfg_s;
        take_s ##0 !seen_wr_r && i_svc_wdata[5:1] == `WSW_KEY_VAL;
    endsequence
    pin_low_only_a: assert property (o_fault_pin_out == 1'b0)
        else $error("fault pin driven high");
    error_pulls_a: assert property (o_wd_error |-> !o_fault_pin_oe_n)
        else $error("error without pin drive");
    bad_key_a: assert property (bad_key_s |-> ##2 o_wd_error)
        else $error("bad key not faulted");
    key_hidden_a: assert property (o_svc_rdata[5:1] == 5'h00)
        else $error("key visible on readback");
    option_gates_a: assert property ($rose(o_wd_error) |->
        $past(i_wd_option, 2))
        else $error("fault with option off");
    rdata_once_a: assert property ($changed(o_svc_rdata) |->
        $past(i_svc_wr, 2))
        else $error("readback moved without write");
    cfg_read_a: assert property (first_cfg_s |-> ##2
        o_svc_rdata == ($past(i_svc_wdata, 2) & 8'hc1))
        else $error("config fields not stored");
    hold_len_a: assert property ($rose(o_fault_pin_oe_n) |->
        ticks_r inside {[16:32]})
        else $error("pin hold length off");
endmodule : wsw_monitor
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the service window block
// assumes wsw_top and wsw_monitor are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic       i_ref_clk = 1'b0;
    logic       i_rst = 1'b1;
    logic       i_wd_option = 1'b1;
    logic       i_idle_timer_clk = 1'b0;
    logic       i_instr_clk = 1'b0;
    logic       i_svc_wr = 1'b0;
    logic [7:0] i_svc_wdata = 8'h00;
    logic [7:0] o_svc_rdata;
    logic       o_fault_pin_out;
    logic       o_fault_pin_oe_n;
    logic       o_wd_error;
    wire        pin_level;
    logic       instr_run = 1'b1;
    logic [2:0] div_r = 3'h0;
    int         errors = 0;
    int         checked = 0;
    int         cyc = 0;
    int         k;
    // pull-up on the pin, low while driven
    assign pin_level = o_fault_pin_oe_n ? 1'b1 : o_fault_pin_out;
    wsw_top wsw_top_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_wd_option(i_wd_option), .i_idle_timer_clk(i_idle_timer_clk),
        .i_instr_clk(i_instr_clk), .i_svc_wr(i_svc_wr),
        .i_svc_wdata(i_svc_wdata), .o_svc_rdata(o_svc_rdata),
        .i_fault_pin_in(pin_level), .o_fault_pin_out(o_fault_pin_out),
        .o_fault_pin_oe_n(o_fault_pin_oe_n), .o_wd_error(o_wd_error));
    always #5 i_ref_clk = ~i_ref_clk;
    // idle clock every 2 cycles, instr clock every 8, hang guard
    always @(posedge i_ref_clk)
    begin
        div_r <= div_r + 3'h1;
        i_idle_timer_clk <= div_r[0];
        i_instr_clk <= instr_run ? div_r[2] : 1'b0;
        cyc <= cyc + 1;
        if (cyc == 98000)
        begin
            errors = errors + 1;
            complete_run();
        end
    end
    // ==========================================
    // tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked = checked + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] d);
        @(posedge i_ref_clk);
        i_svc_wr <= 1'b1;
        i_svc_wdata <= d;
        @(posedge i_ref_clk);
        i_svc_wr <= 1'b0;
    endtask : wr
    // wait n idle ticks, the error output must stay low throughout
    task automatic ticks(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n * 2)
        begin
            @(posedge i_ref_clk);
            #1;
            if (o_wd_error !== 1'b0)
                seen = 1'b1;
        end
        chk({7'h00, seen}, 8'h00);
    endtask : ticks
    // outputs are looked at 1 ns after the edge, once settled
    task automatic wait_err(input logic v, input int n);
        #1;
        for (k = 0; k < n && o_wd_error !== v; k++)
        begin
            @(posedge i_ref_clk);
            #1;
        end
        chk({7'h00, o_wd_error}, {7'h00, v});
    endtask : wait_err
    task automatic do_reset;
        i_rst <= 1'b1;
        repeat (10) @(posedge i_ref_clk);
        i_rst <= 1'b0;
    endtask : do_reset
    task automatic complete_run;
        if (errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    // ==========================================
    // main sequence
    initial
    begin
        do_reset();
        #1 chk(o_svc_rdata, 8'hc1);
        chk({6'h00, o_fault_pin_oe_n, o_wd_error}, 8'h02);
        @(posedge i_ref_clk) i_wd_option <= 1'b0;
        wr(8'h00);
        @(posedge i_ref_clk) i_wd_option <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        #1 chk({o_svc_rdata[7:1], o_wd_error}, 8'hc0);
        wr(8'h19);
        @(posedge i_ref_clk);
        #1 chk(o_svc_rdata, 8'h01);
        // service inside the lower limit
        wr(8'h19);
        wait_err(1'b1, 6);
        chk({7'h00, o_fault_pin_oe_n}, 8'h00);
        wait_err(1'b0, 400);
        @(posedge i_ref_clk);
        #1 chk({7'h00, o_fault_pin_oe_n}, 8'h01);
        ticks(6200);
        wr(8'h19);
        // past 8k from the hold, not from the service
        ticks(6200);
        wr(8'h19);
        wait_err(1'b0, 3);
        ticks(2100);
        // window field differs from stored value
        wr(8'h59);
        wait_err(1'b1, 6);
        wait_err(1'b0, 400);
        ticks(8000);
        chk({7'h00, o_wd_error}, 8'h00);
        wait_err(1'b1, 1000);
        wait_err(1'b0, 400);
        do_reset();
        // first write with a wrong key
        wr(8'h5f);
        wait_err(1'b1, 6);
        wait_err(1'b0, 400);
        // stop the instruction clock: no error before the timeout
        @(posedge i_ref_clk) instr_run <= 1'b0;
        repeat (9900) @(posedge i_ref_clk);
        #1 chk({7'h00, o_fault_pin_oe_n}, 8'h01);
        for (k = 0; k < 600 && o_fault_pin_oe_n !== 1'b0; k++)
        begin
            @(posedge i_ref_clk);
            #1;
        end
        chk({6'h00, o_fault_pin_oe_n, o_wd_error}, 8'h00);
        // 16k window with the monitor off, instruction clock still stopped
        do_reset();
        wr(8'h58);
        @(posedge i_ref_clk);
        #1 chk(o_svc_rdata, 8'h40);
        ticks(16000);
        chk({7'h00, o_fault_pin_oe_n}, 8'h01);
        wait_err(1'b1, 1000);
        wait_err(1'b0, 400);
        complete_run();
    end
endmodule : tb
bind wsw_top wsw_monitor wsw_monitor_inst (.i_ref_clk(i_ref_clk),
    .i_rst(i_rst), .i_wd_option(i_wd_option),
    .i_idle_timer_clk(i_idle_timer_clk), .i_svc_wr(i_svc_wr),
    .i_svc_wdata(i_svc_wdata), .o_svc_rdata(o_svc_rdata),
    .i_fault_pin_in(i_fault_pin_in), .o_fault_pin_out(o_fault_pin_out),
    .o_fault_pin_oe_n(o_fault_pin_oe_n), .o_wd_error(o_wd_error));
`default_nettype wire
